//--- hdl/sdbm_core.v
// Command side of a four-bank SDRAM: bursts, interrupts, mode register.
// Assumes a controller that keeps its own timing duties.
// Summary of operation
// - Precharge may end a read early
// - Write words captured from command edge on
// - Data pins released after burst ends
// - Sequential full page burst wraps to column 0
// - Writes interruptible by write, precharge, read
// - Interrupting read stops further write capture
// - Other-bank access allowed during auto precharge
// - Read interrupts auto-precharge read, precharge starts
// - Write interrupts auto-precharge read immediately
// - Read ends auto-precharge write, recovery follows
// - Write ends auto-precharge write, recovery follows
// - Mode command loads bank and address lines
// - Mode register field layout
// - Burst length coding, reserved codes
// - CAS latency coding two or three
// - Burst order sequential or interleaved
// - Single-word write option
`include "sdbm_defines.vh"
module sdbm_core
(
   input wire clk_in,
   input wire nrst_in,
   input wire cs_n_in,
   input wire ras_n_in,
   input wire cas_n_in,
   input wire we_n_in,
   input wire [1:0] bank_select_in,
   input wire [10:0] addr_in,
   input wire [3:0] dqm_in,
   input wire [31:0] dq_in,
   output reg [31:0] dq_out,
   output reg dq_oe_out,
   output reg wr_en_out,
   output reg [1:0] wr_bank_out,
   output reg [7:0] wr_col_out,
   output reg [31:0] wr_data_out,
   output reg [3:0] wr_be_out,
   output reg rd_req_out,
   output reg [1:0] rd_bank_out,
   output reg [7:0] rd_col_out,
   input wire [31:0] rd_data_in,
   output reg [3:0] pre_start_out,
   output reg [12:0] mode_out
);
   // ======================================================
   // Burst state machine
   localparam ST_IDLE = 3'b001;
   localparam ST_RD = 3'b010;
   localparam ST_WR = 3'b100;
   localparam [31:0] TWR_FULL = `SDBM_TWR_CYC;
   reg [2:0] state_r;
   reg [8:0] left_r;
   reg [1:0] bank_r;
   reg ap_r;
   reg [12:0] mode_r;
   reg [3:0] rd_pipe_r;
   reg [3:0] mask_pipe_r;
   reg [3:0] mask_d1_r;
   reg [1:0] twr_bank_r;
   reg [3:0] twr_cnt_r;
   reg [31:0] rd_hold_r;
   wire [7:0] col;
   wire [2:0] cmd = {ras_n_in, cas_n_in, we_n_in};
   wire sel = !cs_n_in;
   wire is_rd = sel && cmd == `SDBM_CMD_READ;
   wire is_wr = sel && cmd == `SDBM_CMD_WRITE;
   wire is_pre = sel && cmd == `SDBM_CMD_PRE;
   wire is_stop = sel && cmd == `SDBM_CMD_STOP;
   wire is_mode = sel && cmd == `SDBM_CMD_MODE;
   wire [2:0] bl_code = mode_r[`SDBM_BL_MSB:`SDBM_BL_LSB];
   wire wbl_single = mode_r[`SDBM_WBL_BIT];
   wire cl3 = mode_r[`SDBM_CL_MSB:`SDBM_CL_LSB] == `SDBM_CL_3;

   // Words in a burst; reserved codes treated as one word
   function [8:0] burst_words;
      input [2:0] code;
      begin
         case (code)
            `SDBM_BL_2: burst_words = 9'h002;
            `SDBM_BL_4: burst_words = 9'h004;
            `SDBM_BL_8: burst_words = 9'h008;
            `SDBM_BL_PAGE: burst_words = 9'h1FF;
            default: burst_words = 9'h001;
         endcase
      end
   endfunction

   wire wr_start = is_wr;
   wire wr_go = wr_start || (state_r == ST_WR && !is_rd && !is_pre
                             && !is_stop && left_r != 9'h000);
   wire rd_go = is_rd || (state_r == ST_RD && !is_wr && !is_pre
                          && !is_stop && left_r != 9'h000);

   sdbm_colgen u_col
   (
      .clk_in(clk_in),
      .nrst_in(nrst_in),
      .start_in(is_rd || is_wr),
      .start_col_in(addr_in[7:0]),
      .step_in(rd_go || wr_go),
      .interleave_in(mode_r[`SDBM_BT_BIT]),
      .bl_code_in(bl_code),
      .col_out(col)
   );

   // ======================================================
   // Command and burst tracking
   always @(posedge clk_in)
   begin
      if (!nrst_in)
      begin
         state_r <= ST_IDLE;
         left_r <= 9'h000;
         bank_r <= 2'h0;
         ap_r <= 1'b0;
         mode_r <= `SDBM_MODE_RST;
         wr_en_out <= 1'b0;
         wr_bank_out <= 2'h0;
         wr_col_out <= 8'h00;
         wr_data_out <= 32'h0000_0000;
         wr_be_out <= 4'h0;
         rd_req_out <= 1'b0;
         rd_bank_out <= 2'h0;
         rd_col_out <= 8'h00;
         pre_start_out <= 4'h0;
         twr_bank_r <= 2'h0;
         twr_cnt_r <= 4'h0;
         mode_out <= `SDBM_MODE_RST;
      end
      else
      begin
         pre_start_out <= 4'h0;
         // Write capture on command edge and each later edge
         wr_en_out <= wr_go;
         wr_bank_out <= is_wr ? bank_select_in : bank_r;
         wr_data_out <= dq_in;
         wr_be_out <= ~dqm_in;
         wr_col_out <= is_wr ? addr_in[7:0] : col;
         rd_req_out <= rd_go;
         rd_bank_out <= is_rd ? bank_select_in : bank_r;
         rd_col_out <= is_rd ? addr_in[7:0] : col;
         if (twr_cnt_r != 4'h0)
         begin
            twr_cnt_r <= twr_cnt_r - 4'h1;
            if (twr_cnt_r == 4'h1)
               pre_start_out[twr_bank_r] <= 1'b1;
         end
         if (is_mode)
         begin
            mode_r <= {bank_select_in, addr_in};
            mode_out <= {bank_select_in, addr_in};
         end
         if (is_rd || is_wr)
         begin
            // Other-bank access ends an auto-precharge burst
            if (ap_r && state_r == ST_RD)
               pre_start_out[bank_r] <= 1'b1;
            if (ap_r && state_r == ST_WR)
            begin
               twr_bank_r <= bank_r;
               twr_cnt_r <= TWR_FULL[3:0];
            end
            state_r <= is_rd ? ST_RD : ST_WR;
            bank_r <= bank_select_in;
            ap_r <= addr_in[10];
            if (is_wr && wbl_single)
               left_r <= 9'h000;
            else if (bl_code == `SDBM_BL_PAGE)
               left_r <= 9'h1FF;
            else
               left_r <= burst_words(bl_code) - 9'h001;
         end
         else if (is_pre || is_stop)
         begin
            state_r <= ST_IDLE;
            left_r <= 9'h000;
            ap_r <= 1'b0;
         end
         else if (state_r != ST_IDLE)
         begin
            if (left_r == 9'h000)
            begin
               state_r <= ST_IDLE;
               ap_r <= 1'b0;
               if (ap_r)
                  pre_start_out[bank_r] <= 1'b1;
            end
            else if (bl_code != `SDBM_BL_PAGE)
               left_r <= left_r - 9'h001;
         end
      end
   end

   // ======================================================
   // Read data pipeline, CAS latency and mask latency of two
   always @(posedge clk_in)
   begin
      if (!nrst_in)
      begin
         rd_pipe_r <= 4'h0;
         rd_hold_r <= 32'h0000_0000;
         mask_d1_r <= 4'hF;
         mask_pipe_r <= 4'hF;
         dq_out <= 32'h0000_0000;
         dq_oe_out <= 1'b0;
      end
      else
      begin
         rd_pipe_r <= {rd_pipe_r[2:0], rd_go && !is_wr};
         mask_d1_r <= dqm_in;
         mask_pipe_r <= mask_d1_r;
         // Latency three holds each fetched word one clock longer
         rd_hold_r <= rd_data_in;
         dq_out <= cl3 ? rd_hold_r : rd_data_in;
         // A write cancels pending output so both drivers never meet
         dq_oe_out <= !is_wr && !(state_r == ST_WR)
                      && (cl3 ? rd_pipe_r[2] : rd_pipe_r[1])
                      && mask_pipe_r != 4'hF;
      end
   end
endmodule // sdbm_core

//--- hdl/sdbm_defines.vh
// Constants for the burst and mode-register command block.
// Included by the burst tracker and the command core; no logic here.
`ifndef SDBM_DEFINES_VH
`define SDBM_DEFINES_VH
// ======================================================
// Mode register field positions
`define SDBM_MODE_W 13
`define SDBM_BL_LSB 0
`define SDBM_BL_MSB 2
`define SDBM_BT_BIT 3
`define SDBM_CL_LSB 4
`define SDBM_CL_MSB 6
`define SDBM_TM_LSB 7
`define SDBM_TM_MSB 8
`define SDBM_WBL_BIT 9
`define SDBM_MODE_RST 13'h0022
// ======================================================
// Burst length and latency codes
`define SDBM_BL_1 3'h0
`define SDBM_BL_2 3'h1
`define SDBM_BL_4 3'h2
`define SDBM_BL_8 3'h3
`define SDBM_BL_PAGE 3'h7
`define SDBM_CL_2 3'h2
`define SDBM_CL_3 3'h3
// ======================================================
// Commands as {ras_n, cas_n, we_n}
`define SDBM_CMD_MODE 3'h0
`define SDBM_CMD_PRE 3'h2
`define SDBM_CMD_READ 3'h5
`define SDBM_CMD_WRITE 3'h4
`define SDBM_CMD_STOP 3'h6
// ======================================================
// Timing
`define SDBM_CLK_PS 25000
`define SDBM_TWR_PS 15000
`define SDBM_TWR_CYC ((`SDBM_TWR_PS + `SDBM_CLK_PS - 1) / `SDBM_CLK_PS)
`endif

//--- hdl/sdbm_colgen.v
// Column address sequencer for one burst.
// Assumes start pulses only when a burst begins; step once per data word.
`include "sdbm_defines.vh"
module sdbm_colgen
(
   input wire clk_in,
   input wire nrst_in,
   input wire start_in,
   input wire [7:0] start_col_in,
   input wire step_in,
   input wire interleave_in,
   input wire [2:0] bl_code_in,
   output reg [7:0] col_out
);
   reg [7:0] base_r;
   reg [7:0] cnt_r;
   reg [7:0] wmask;
   reg [7:0] cnt_nxt;
   always @*
   begin
      case (bl_code_in)
         `SDBM_BL_2: wmask = 8'h01;
         `SDBM_BL_4: wmask = 8'h03;
         `SDBM_BL_8: wmask = 8'h07;
         `SDBM_BL_PAGE: wmask = 8'hFF;
         default: wmask = 8'h00;
      endcase
      // First word takes the command column; start points at the second
      cnt_nxt = start_in ? 8'h01 : cnt_r + 8'h01;
   end
   // Sequential page bursts wrap naturally at column 255 to column 0
   always @(posedge clk_in)
   begin
      if (!nrst_in)
      begin
         base_r <= 8'h00;
         cnt_r <= 8'h00;
         col_out <= 8'h00;
      end
      else if (start_in || step_in)
      begin
         if (start_in)
            base_r <= start_col_in;
         cnt_r <= cnt_nxt;
         if (interleave_in)
            col_out <= ((start_in ? start_col_in : base_r) & ~wmask) |
                       (((start_in ? start_col_in : base_r) ^ cnt_nxt)
                        & wmask);
         else
            col_out <= ((start_in ? start_col_in : base_r) & ~wmask) |
                       (((start_in ? start_col_in : base_r) + cnt_nxt)
                        & wmask);
      end
   end
endmodule // sdbm_colgen

//--- dv/sdbm_array_model.sv
// Array model: answers each fetch of the block.
// Assumes fetches stand one clock.
module sdbm_array_model
(
   input logic clk_in,
   input logic rd_req_in,
   input logic [1:0] rd_bank_in,
   input logic [7:0] rd_col_in,
   output logic [31:0] rd_data_out
);
timeunit 1ns;
timeprecision 100ps;
initial rd_data_out = 32'h0;
// Idle cycles toggle so stale data never matches
always @(posedge clk_in)
   if (rd_req_in)
      rd_data_out <= {8'hD0, 14'h0, rd_bank_in, rd_col_in};
   else
      rd_data_out <= ~rd_data_out;
endmodule // sdbm_array_model

//--- dv/sdbm_core_assertions.sv
// Port checker of the burst and mode block.
// Assumes one clock, synchronous low reset.
`include "sdbm_defines.vh"
module sdbm_core_chk
(
   input logic clk_in,
   input logic nrst_in,
   input logic cs_n_in,
   input logic ras_n_in,
   input logic cas_n_in,
   input logic we_n_in,
   input logic [1:0] bank_select_in,
   input logic [10:0] addr_in,
   input logic [3:0] dqm_in,
   input logic [31:0] dq_in,
   input logic wr_en_out,
   input logic [31:0] wr_data_out,
   input logic [3:0] wr_be_out,
   input logic rd_req_out,
   input logic [7:0] rd_col_out,
   input logic [12:0] mode_out
);
timeunit 1ns;
timeprecision 100ps;
wire [2:0] c = {ras_n_in, cas_n_in, we_n_in};
wire [12:0] mi = {bank_select_in, addr_in};
wire [7:0] ac = addr_in[7:0];
wire md = !cs_n_in && c == `SDBM_CMD_MODE;
wire one = mode_out[2:0] == `SDBM_BL_1 || mode_out[9];
default clocking @(posedge clk_in); endclocking
default disable iff (!nrst_in);
sequence s_wr; !cs_n_in && c == `SDBM_CMD_WRITE && dqm_in != 4'hF;
endsequence
sequence s_rd; !cs_n_in && c == `SDBM_CMD_READ; endsequence
sequence s_pre; !cs_n_in && c == `SDBM_CMD_PRE; endsequence
sequence s_nop; cs_n_in || c == 3'h7; endsequence
AST_MODE_LOAD:
   assert property (md |=> mode_out == $past(mi)) else $error("mode load");
AST_MODE_HOLD:
   assert property (!md |=> $stable(mode_out)) else $error("mode drift");
AST_WR_DATA:
   assert property (s_wr |=> wr_en_out && wr_data_out == $past(dq_in))
      else $error("write word");
AST_WR_BE:
   assert property (s_wr |=> wr_be_out == ~$past(dqm_in))
      else $error("write mask");
AST_RD_STOP:
   assert property (s_rd |=> !wr_en_out) else $error("write after read");
AST_RD_FETCH:
   assert property (s_rd |=> rd_req_out && rd_col_out == $past(ac))
      else $error("read fetch");
AST_ONE_WORD:
   assert property (s_wr ##0 one ##1 s_nop |=> !wr_en_out)
      else $error("single write");
AST_PRE_END:
   assert property (s_pre ##1 s_nop |=> !wr_en_out)
      else $error("write after precharge");
endmodule // sdbm_core_chk
bind sdbm_core sdbm_core_chk sdbm_core_chk_i (.clk_in, .nrst_in, .cs_n_in,
   .ras_n_in, .cas_n_in, .we_n_in, .bank_select_in, .addr_in, .dqm_in,
   .dq_in, .wr_en_out, .wr_data_out, .wr_be_out, .rd_req_out,
   .rd_col_out, .mode_out);

//--- dv/sdbm_core_tb.sv
// Self-checking bench of the burst and mode block.
// Assumes the array model answers fetches a clock later.
`include "sdbm_defines.vh"
module sdbm_core_tb;
timeunit 1ns;
timeprecision 100ps;
logic clk_in = 1'b0, nrst_in = 1'b0, cs_n_in = 1'b1, ras_n_in = 1'b1;
logic cas_n_in = 1'b1, we_n_in = 1'b1;
logic [1:0] bank_select_in = 2'h0;
logic [10:0] addr_in = 11'h000;
logic [3:0] dqm_in = 4'h0, pseen = 4'h0;
logic [31:0] dq_in = 32'h0, dq_out, wr_data_out, rd_data_in;
logic dq_oe_out, wr_en_out, rd_req_out;
logic [1:0] wr_bank_out, rd_bank_out;
logic [7:0] wr_col_out, rd_col_out;
logic [3:0] wr_be_out, pre_start_out;
logic [12:0] mode_out;
logic [47:0] wq[$], rq[$];
int fail_count = 0, checked = 0, cyc = 0, tcmd = 0;
always #12.5 clk_in = ~clk_in;
sdbm_core sdbm_core_i (.clk_in, .nrst_in, .cs_n_in, .ras_n_in,
   .cas_n_in, .we_n_in, .bank_select_in, .addr_in, .dqm_in, .dq_in,
   .dq_out, .dq_oe_out, .wr_en_out, .wr_bank_out, .wr_col_out,
   .wr_data_out, .wr_be_out, .rd_req_out, .rd_bank_out, .rd_col_out,
   .rd_data_in, .pre_start_out, .mode_out);
sdbm_array_model sdbm_array_model_i (.clk_in, .rd_req_in(rd_req_out),
   .rd_bank_in(rd_bank_out), .rd_col_in(rd_col_out),
   .rd_data_out(rd_data_in));
// ==========================================
// Capture of written words and read words
always @(posedge clk_in)
begin
   cyc <= cyc + 1;
   if (nrst_in)
      pseen <= pseen | pre_start_out;
   if (wr_en_out === 1'b1)
      wq.push_back({2'h0, wr_be_out, wr_bank_out, wr_col_out, wr_data_out});
   if (dq_oe_out === 1'b1)
      rq.push_back({cyc[15:0], dq_out});
end
task chk(input string n, input logic [47:0] e, input logic [47:0] g);
   checked++;
   if (g !== e)
   begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
   end
endtask
task cmd(input logic [2:0] c, input logic [1:0] b, input logic [10:0] a);
   {cs_n_in, ras_n_in, cas_n_in, we_n_in} = {1'b0, c};
   bank_select_in = b;
   addr_in = a;
   tcmd = cyc;
   @(negedge clk_in);
endtask
task nop(input int n);
   cmd(3'h7, 2'h0, 11'h000);
   repeat (n) @(negedge clk_in);
endtask
task mode(input logic [12:0] m);
   cmd(`SDBM_CMD_MODE, m[12:11], m[10:0]);
   nop(1);
   chk("mode", 48'(m), 48'(mode_out));
endtask
task wr(input logic [1:0] b, input logic [10:0] a, input int n);
   for (int k = 0; k < n; k++)
   begin
      dq_in = {24'h5A5A5A, 8'(k)};
      if (k == 0)
         cmd(`SDBM_CMD_WRITE, b, a);
      else
         nop(0);
   end
endtask
task expw(input logic [1:0] b, input logic [7:0] c, input int n,
   input logic il, input int left);
   chk("wcount", 48'(n + left), 48'(wq.size()));
   for (int k = 0; k < n && wq.size() > 0; k++)
      chk("wword", {6'h0F, b, il ? c ^ 8'(k) : c + 8'(k), 24'h5A5A5A,
         8'(k)}, wq.pop_front());
   if (left == 0)
      wq.delete();
endtask
task expr(input logic [1:0] b, input logic [7:0] c, input int t, l);
   chk("rcount", 48'h4, 48'(rq.size()));
   for (int k = 0; k < 4 && rq.size() > 0; k++)
      chk("rword", {16'(t + l + 1 + k), 8'hD0, 14'h0, b, c + 8'(k)},
         rq.pop_front());
   rq.delete();
endtask
// ==========================================
// Scenarios
task automatic t_bl;
   logic [12:0] mt[6] = '{13'h020, 13'h021, 13'h022, 13'h023, 13'h024,
      13'h223};
   int nt[6] = '{1, 2, 4, 8, 1, 1};
   for (int i = 0; i < 6; i++)
   begin
      mode(mt[i]);
      wr(2'h0, 11'h020, 9);
      nop(3);
      expw(2'h0, 8'h20, nt[i], 1'b0, 0);
   end
endtask
task t_order;
   mode(13'h022);
   wr(2'h1, 11'h010, 4);
   nop(3);
   expw(2'h1, 8'h10, 4, 1'b0, 0);
   mode(13'h02A);
   wr(2'h1, 11'h005, 4);
   nop(3);
   expw(2'h1, 8'h05, 4, 1'b1, 0);
   mode(13'h027);
   wr(2'h2, 11'h0FE, 4);
   cmd(`SDBM_CMD_STOP, 2'h0, 11'h000);
   nop(3);
   expw(2'h2, 8'hFE, 4, 1'b0, 0);
   mode(13'h022);
   wr(2'h0, 11'h080, 2);
   dqm_in = 4'hF;
   cmd(`SDBM_CMD_PRE, 2'h0, 11'h000);
   dqm_in = 4'h0;
   nop(3);
   expw(2'h0, 8'h80, 2, 1'b0, 0);
endtask
task t_read;
   int t;
   for (int l = 2; l < 4; l++)
   begin
      mode(13'(l * 16 + 2));
      cmd(`SDBM_CMD_READ, 2'h1, 11'h008);
      t = tcmd;
      nop(8);
      expr(2'h1, 8'h08, t, l);
   end
   wr(2'h1, 11'h430, 2);
   cmd(`SDBM_CMD_READ, 2'h0, 11'h040);
   t = tcmd;
   nop(8);
   expw(2'h1, 8'h30, 2, 1'b0, 0);
   expr(2'h0, 8'h40, t, 3);
   chk("pre16", 48'h2, 48'(pseen));
   cmd(`SDBM_CMD_READ, 2'h3, 11'h050);
   cmd(`SDBM_CMD_PRE, 2'h3, 11'h000);
   nop(8);
   chk("rcut", 48'h1, 48'(rq.size()));
   rq.delete();
endtask
task t_conc;
   mode(13'h022);
   wr(2'h0, 11'h410, 2);
   wr(2'h1, 11'h060, 4);
   nop(4);
   expw(2'h0, 8'h10, 2, 1'b0, 4);
   expw(2'h1, 8'h60, 4, 1'b0, 0);
   cmd(`SDBM_CMD_READ, 2'h2, 11'h400);
   dqm_in = 4'hF;
   nop(2);
   dqm_in = 4'h0;
   wr(2'h3, 11'h070, 1);
   nop(4);
   cmd(`SDBM_CMD_READ, 2'h3, 11'h400);
   cmd(`SDBM_CMD_READ, 2'h0, 11'h000);
   nop(8);
   wq.delete();
   rq.delete();
   chk("prestart", 48'hF, 48'(pseen));
endtask
task end_of_test;
   $display("checked %0d fail_count %0d", checked, fail_count);
   if (fail_count == 0 && checked > 0)
      $display("ALL CHECKS OK");
   else
      $display("CHECKS NOT OK");
   $finish;
endtask
initial
begin
   repeat (5) @(negedge clk_in);
   nrst_in = 1'b1;
   chk("mreset", 48'h22, 48'(mode_out));
   chk("oereset", 48'h0, 48'(dq_oe_out));
   t_bl;
   t_order;
   t_read;
   t_conc;
   end_of_test;
end
initial
begin
   repeat (4000) @(posedge clk_in);
   fail_count++;
   end_of_test;
end
endmodule // sdbm_core_tb
